// >>> logic/esc_pkg.sv
// Shared constants for the error signalling and command unit
package esc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PROTOCOL = 8'h0b;     // Serial protocol select
  localparam logic [7:0] IDX_MASK = 8'h0c;         // Error and warning mask
  localparam logic [7:0] IDX_HOLD = 8'h0d;         // Error hold time and accumulate
  localparam logic [7:0] IDX_COMMAND = 8'h75;      // Command trigger, write only
  localparam logic [7:0] IDX_UNIT_STATUS = 8'h40;  // Busy, consistency flags, pin levels
  localparam logic [7:0] IDX_EVENT_COUNT = 8'h41;  // Event counter
  localparam logic [7:0] IDX_PORT_CFG = 8'h42;     // Error pin enable and turns mode

  // Reset values
  localparam logic [7:0] RST_PROTOCOL = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'h00;
  localparam logic [7:0] RST_EVENT_COUNT = 8'h00;
  localparam logic [1:0] RST_PORT_CFG = 2'h0;

  // Field positions
  localparam int HOLD_ACC_BIT = 7;       // Accumulate select in the hold register
  localparam int PORT_ERRPIN_BIT = 0;    // Port B line 3 works as error pin
  localparam int PORT_TURNS_BIT = 1;     // External multiturn configured
  localparam int MASK_TURNS = 7;
  localparam int MASK_PERIOD = 6;
  localparam int MASK_AMP_ERR = 5;
  localparam int MASK_EEPROM = 4;
  localparam int MASK_CRC = 3;
  localparam int MASK_BUSY = 2;
  localparam int MASK_SPEED = 1;
  localparam int MASK_AMP_WARN = 0;

  // Serial protocol codes
  localparam logic [2:0] PROTO_SPI_TRI = 3'h0;
  localparam logic [2:0] PROTO_SPI = 3'h1;
  localparam logic [2:0] PROTO_BISS = 3'h2;
  localparam logic [2:0] PROTO_QUAD = 3'h3;
  localparam logic [2:0] PROTO_SSI = 3'h4;
  localparam logic [2:0] PROTO_SSI_ERR_LOW = 3'h5;
  localparam logic [2:0] PROTO_SSI_ERR_HIGH = 3'h6;
  localparam logic [2:0] PROTO_EXT_SSI = 3'h7;

  // Command codes
  localparam logic [7:0] CMD_STORE_ALL = 8'h01;
  localparam logic [7:0] CMD_STORE_OFFSETS = 8'h02;
  localparam logic [7:0] CMD_ABS_REDEFINE = 8'h03;
  localparam logic [7:0] CMD_VERNIER_VERIFY = 8'h04;
  localparam logic [7:0] CMD_TURNS_RESYNC = 8'h05;
  localparam logic [7:0] CMD_TURNS_VERIFY = 8'h06;
  localparam logic [7:0] CMD_RESTART = 8'h07;
  localparam logic [7:0] CMD_PRESET = 8'h08;
  localparam logic [7:0] CMD_PRESET_STORE = 8'h09;
  localparam logic [7:0] CMD_TWO_WIRE = 8'h0a;
  localparam logic [7:0] CMD_EVENT_COUNT = 8'h0b;
  localparam logic [7:0] CMD_SWAP_STORE = 8'h0c;
  localparam logic [7:0] CMD_CSUM_VERIFY = 8'h0d;
  localparam logic [7:0] CMD_CSUM_RECALC = 8'h0e;
  localparam logic [7:0] CMD_TURNS_CLK_HIGH = 8'h0f;
  localparam logic [7:0] CMD_TURNS_CLK_LOW = 8'h10;
  localparam int ACT_WIDTH = 16;          // One start line per code 0x01..0x10

  // Error hold timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int HOLD_STEP_NS = 12500000;  // 12.5 ms per code step
  localparam int HOLD_STEP_CYCLES = HOLD_STEP_NS / CLK_PERIOD_NS;

endpackage

// >>> logic/esc_flag_router.sv
// Masks internal conditions onto the error and warning terms
`timescale 1ns/100ps
module esc_flag_router
  import esc_pkg::*;
(
  // Configuration
  input wire logic [7:0] mask_in,
  // Conditions
  input wire logic turns_link_error_in,
  input wire logic turns_consistency_error_in,
  input wire logic period_consistency_error_in,
  input wire logic [1:0] amplitude_clip_in,
  input wire logic [1:0] amplitude_low_in,
  input wire logic eeprom_error_in,
  input wire logic checksum_error_in,
  input wire logic command_busy_in,
  input wire logic converter_overspeed_in,
  input wire logic quadrature_overspeed_in,
  // Results
  output logic err_sticky_out,
  output logic err_live_out,
  output logic warn_out
);

  logic amp_any;  // Clip or low level on either track

  // A mask bit at 0 passes its condition, at 1 blocks it
  always_comb begin
    amp_any = |amplitude_clip_in | |amplitude_low_in;
    err_sticky_out = (~mask_in[MASK_TURNS] & (turns_link_error_in | turns_consistency_error_in)) |
                     (~mask_in[MASK_PERIOD] & period_consistency_error_in) |
                     (~mask_in[MASK_AMP_ERR] & amp_any) |
                     (~mask_in[MASK_CRC] & checksum_error_in);
    // Eeprom and busy terms never accumulate, they follow the live state
    err_live_out = (~mask_in[MASK_EEPROM] & eeprom_error_in) |
                   (~mask_in[MASK_BUSY] & command_busy_in);
    warn_out = (~mask_in[MASK_SPEED] & (converter_overspeed_in | quadrature_overspeed_in)) |
               (~mask_in[MASK_AMP_WARN] & amp_any);
  end

endmodule // esc_flag_router

// >>> logic/esc_hold_timer.sv
// Minimum display time for the error pin
`timescale 1ns/100ps
module esc_hold_timer
  import esc_pkg::*;
#(
  parameter int STEP_CYCLES = HOLD_STEP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Error and hold code
  input wire logic err_in,
  input wire logic [2:0] code_in,
  // Stretched error
  output logic hold_out
);

  localparam int DIV_W = $clog2(STEP_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYCLES - 1);

  logic err_q;              // Error of the previous cycle
  logic [DIV_W-1:0] div;    // Cycles inside the current step
  logic [2:0] remain;       // Steps still to hold
  logic step_tick;          // One-cycle enable at the end of a step

  assign step_tick = (div == DIV_LAST);

  // Edge memory for new assertions
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_in;
    end
  end

  // Each rising error reloads the hold and restarts the divider
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      remain <= 3'h0;
      div <= '0;
    end else if (err_in && !err_q) begin
      remain <= code_in;
      div <= '0;
    end else if (remain != 3'h0) begin
      if (step_tick) begin
        remain <= remain - 3'h1;
        div <= '0;
      end else begin
        div <= div + DIV_W'(1);
      end
    end
  end

  // Released only when time is out and no error remains
  assign hold_out = err_in | (remain != 3'h0);

endmodule // esc_hold_timer

// >>> logic/esc_unit.sv
// Error signalling and command unit, top level with register slave
//
// Summary of operation
// - Protocol decides presence and polarity of frame bits
// - Mask bits 7..2 gate conditions onto error
// - Mask bits 1..0 gate conditions onto warning
// - Mask bit 0 passes, 1 blocks condition
// - Error pin pulled low only, open collector
// - Error pin held minimum 12.5 ms times code
// - Command codes execute; reserved codes do nothing
// - Code 0x01 stores all, both checksums updated
// - Code 0x02 stores offsets, short checksum updated
// - Code 0x03 redefines absolute position
// - Code 0x04 vernier check sets period error
// - Code 0x05 rereads and resyncs multiturn offsets
// - Code 0x06 verifies multiturn without resync
// - Code 0x07 restarts and rereads eeprom
// - Codes 0x08/0x09 preset, 0x09 also stores
// - Code 0x0A two-wire transfer, 0x0B counts
// - Code 0x0C stores with target protocol substituted
// - Codes 0x0D/0x0E verify or recalculate checksums
// - Codes 0x0F/0x10 drive turns clock, no multiturn
// - Busy flag high while a command runs
// - Multiturn mismatch sets turns consistency error
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
module esc_unit
  import esc_pkg::*;
#(
  parameter int HOLD_STEP_CYCLES_P = HOLD_STEP_CYCLES  // Cycles per 12.5 ms step
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM register slave
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Internal conditions from the position engines
  input wire logic turns_link_error_in,
  input wire logic [1:0] amplitude_clip_in,
  input wire logic [1:0] amplitude_low_in,
  input wire logic eeprom_error_in,
  input wire logic checksum_error_in,
  input wire logic converter_overspeed_in,
  input wire logic quadrature_overspeed_in,
  input wire logic status_read_in,
  // Action engine handshake
  output logic [ACT_WIDTH-1:0] act_start_out,
  output logic twi_store_req_out,
  output logic substitute_target_out,
  input wire logic act_done_in,
  input wire logic act_mismatch_in,
  // Serial frame error and warning bits
  output logic frame_err_present_out,
  output logic frame_err_bit_out,
  output logic frame_warn_present_out,
  output logic frame_warn_bit_out,
  // Pins
  output logic port_b_line3_out,
  output logic port_b_line3_oe_out,
  output logic turns_clock_pin_out,
  output logic command_busy_out
);

  typedef enum logic [0:0] {ESC_IDLE, ESC_RUN} esc_state_e;

  // Command classes after decoding
  typedef enum logic [1:0] {ESC_NONE, ESC_ENGINE, ESC_COUNT, ESC_PIN} esc_class_e;

  // Registers seen by software
  logic [7:0] serial_protocol_select;   // Protocol code in bits 2:0
  logic [7:0] error_warning_mask;       // Condition mask
  logic [7:0] error_hold_time_config;   // Hold code and accumulate select
  logic [7:0] event_count;              // Event counter
  logic [1:0] port_b_function_select;   // Error pin enable, turns mode

  // Command engine state
  esc_state_e state;
  logic [7:0] command_code;             // Code being executed
  logic period_consistency_error;       // Vernier check mismatch
  logic turns_consistency_error;        // Multiturn check mismatch

  // Bus decode
  logic [7:0] reg_index;
  logic bus_write_now;                  // Write that takes effect this edge
  logic cmd_accept;                     // Command write accepted this edge
  esc_class_e cmd_class;

  // Error path
  logic err_sticky;
  logic err_live;
  logic warn_raw;
  logic err_acc;                        // Accumulated sticky error
  logic err_total;
  logic err_hold;

  // Decoding of a command code into its class, used for accept and run
  function automatic esc_class_e classify(input logic [7:0] code, input logic turns_mode);
    if (code == CMD_EVENT_COUNT) begin
      return ESC_COUNT;
    end else if (code == CMD_TURNS_CLK_HIGH || code == CMD_TURNS_CLK_LOW) begin
      return turns_mode ? ESC_NONE : ESC_PIN;
    end else if (code >= CMD_STORE_ALL && code < CMD_TURNS_CLK_HIGH) begin
      return ESC_ENGINE;
    end else begin
      return ESC_NONE;
    end
  endfunction

  // True for codes whose work includes an eeprom store
  function automatic logic is_store(input logic [7:0] code);
    return (code == CMD_STORE_ALL) || (code == CMD_STORE_OFFSETS) ||
           (code == CMD_PRESET_STORE) || (code == CMD_SWAP_STORE) || (code == CMD_ABS_REDEFINE);
  endfunction

  assign reg_index = avs_address_in[9:2];
  assign bus_write_now = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  assign cmd_accept = bus_write_now && (reg_index == IDX_COMMAND) && (state == ESC_IDLE);
  assign cmd_class = classify(avs_writedata_in[7:0], port_b_function_select[PORT_TURNS_BIT]);

  // Waitrequest drops for one cycle per request; the transfer ends at that edge
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  // Read data is loaded as waitrequest drops; unmapped and write-only read zero
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      unique case (reg_index)
        IDX_PROTOCOL: avs_readdata_out <= {24'h00_0000, serial_protocol_select};
        IDX_MASK: avs_readdata_out <= {24'h00_0000, error_warning_mask};
        IDX_HOLD: avs_readdata_out <= {24'h00_0000, error_hold_time_config};
        IDX_EVENT_COUNT: avs_readdata_out <= {24'h00_0000, event_count};
        IDX_PORT_CFG: avs_readdata_out <= {30'h0000_0000, port_b_function_select};
        IDX_UNIT_STATUS: avs_readdata_out <= {26'h000_0000, port_b_line3_oe_out, turns_clock_pin_out,
                                              turns_consistency_error, period_consistency_error,
                                              err_total, command_busy_out};
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers written by software
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      serial_protocol_select <= RST_PROTOCOL;
      error_warning_mask <= RST_MASK;
      error_hold_time_config <= RST_HOLD;
      port_b_function_select <= RST_PORT_CFG;
    end else if (bus_write_now) begin
      if (reg_index == IDX_PROTOCOL) begin
        serial_protocol_select <= avs_writedata_in[7:0];
      end
      if (reg_index == IDX_MASK) begin
        error_warning_mask <= avs_writedata_in[7:0];
      end
      if (reg_index == IDX_HOLD) begin
        error_hold_time_config <= avs_writedata_in[7:0];
      end
      if (reg_index == IDX_PORT_CFG) begin
        port_b_function_select <= avs_writedata_in[1:0];
      end
    end
  end

  // Command sequencer: engine codes start an action and wait for its end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state <= ESC_IDLE;
      command_code <= 8'h00;
      command_busy_out <= 1'b0;
    end else begin
      unique case (state)
        ESC_IDLE: begin
          if (cmd_accept && cmd_class == ESC_ENGINE) begin
            state <= ESC_RUN;
            command_code <= avs_writedata_in[7:0];
            command_busy_out <= 1'b1;
          end
        end
        ESC_RUN: begin
          if (act_done_in) begin
            state <= ESC_IDLE;
            command_busy_out <= 1'b0;
          end
        end
      endcase
    end
  end

  // One start pulse per accepted engine command, bit n-1 for code n
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      act_start_out <= '0;
      twi_store_req_out <= 1'b0;
    end else if (cmd_accept && cmd_class == ESC_ENGINE) begin
      act_start_out <= ACT_WIDTH'(1) << (avs_writedata_in[3:0] - 4'h1);
      // Stores and two-wire transfers go out through the two-wire master
      twi_store_req_out <= is_store(avs_writedata_in[7:0]) || (avs_writedata_in[7:0] == CMD_TWO_WIRE);
    end else begin
      act_start_out <= '0;
      twi_store_req_out <= 1'b0;
    end
  end

  // Target protocol and protection level stand in during the swap store
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      substitute_target_out <= 1'b0;
    end else begin
      substitute_target_out <= (state == ESC_RUN) && (command_code == CMD_SWAP_STORE) && !act_done_in;
    end
  end

  // Event counter steps once per count command
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      event_count <= RST_EVENT_COUNT;
    end else if (cmd_accept && cmd_class == ESC_COUNT) begin
      event_count <= event_count + 8'h01;
    end
  end

  // Turns clock pin is set or cleared directly when no multiturn is attached
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      turns_clock_pin_out <= 1'b0;
    end else if (cmd_accept && cmd_class == ESC_PIN) begin
      turns_clock_pin_out <= (avs_writedata_in[7:0] == CMD_TURNS_CLK_HIGH);
    end
  end

  // Period consistency flag from the vernier check; redefine and restart clear it
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      period_consistency_error <= 1'b0;
    end else if (state == ESC_RUN && act_done_in && command_code == CMD_VERNIER_VERIFY) begin
      period_consistency_error <= act_mismatch_in;
    end else if (state == ESC_RUN && act_done_in &&
                 (command_code == CMD_ABS_REDEFINE || command_code == CMD_RESTART)) begin
      period_consistency_error <= 1'b0;
    end
  end

  // Turns consistency flag from the multiturn verify; resync does not clear it
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      turns_consistency_error <= 1'b0;
    end else if (state == ESC_RUN && act_done_in && command_code == CMD_TURNS_VERIFY) begin
      turns_consistency_error <= act_mismatch_in;
    end else if (state == ESC_RUN && act_done_in &&
                 (command_code == CMD_ABS_REDEFINE || command_code == CMD_RESTART)) begin
      turns_consistency_error <= 1'b0;
    end
  end

  // Condition masking
  esc_flag_router u_router (
    .mask_in(error_warning_mask),
    .turns_link_error_in(turns_link_error_in),
    .turns_consistency_error_in(turns_consistency_error),
    .period_consistency_error_in(period_consistency_error),
    .amplitude_clip_in(amplitude_clip_in),
    .amplitude_low_in(amplitude_low_in),
    .eeprom_error_in(eeprom_error_in),
    .checksum_error_in(checksum_error_in),
    .command_busy_in(command_busy_out),
    .converter_overspeed_in(converter_overspeed_in),
    .quadrature_overspeed_in(quadrature_overspeed_in),
    .err_sticky_out(err_sticky),
    .err_live_out(err_live),
    .warn_out(warn_raw)
  );

  // Accumulated error holds until a status read or a redefine or restart; a new error wins
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      err_acc <= 1'b0;
    end else if (!error_hold_time_config[HOLD_ACC_BIT]) begin
      err_acc <= 1'b0;
    end else if (err_sticky) begin
      err_acc <= 1'b1;
    end else if (status_read_in || (cmd_accept && (avs_writedata_in[7:0] == CMD_ABS_REDEFINE ||
                                                   avs_writedata_in[7:0] == CMD_RESTART))) begin
      err_acc <= 1'b0;
    end
  end

  assign err_total = err_sticky | err_live | err_acc;

  // Minimum display stretch for the pin
  esc_hold_timer #(
    .STEP_CYCLES(HOLD_STEP_CYCLES_P)
  ) u_hold (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .err_in(err_total),
    .code_in(error_hold_time_config[2:0]),
    .hold_out(err_hold)
  );

  // Open-collector pin: level always low, enable pulls the line down
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      port_b_line3_out <= 1'b0;
      port_b_line3_oe_out <= 1'b0;
    end else begin
      port_b_line3_out <= 1'b0;
      port_b_line3_oe_out <= port_b_function_select[PORT_ERRPIN_BIT] && err_hold;
    end
  end

  // Frame bits by protocol; absent bits rest at 0
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      frame_err_present_out <= 1'b0;
      frame_err_bit_out <= 1'b0;
      frame_warn_present_out <= 1'b0;
      frame_warn_bit_out <= 1'b0;
    end else begin
      unique case (serial_protocol_select[2:0])
        PROTO_BISS, PROTO_EXT_SSI: begin
          frame_err_present_out <= 1'b1;
          frame_err_bit_out <= ~err_total;
          frame_warn_present_out <= 1'b1;
          frame_warn_bit_out <= ~warn_raw;
        end
        PROTO_SSI_ERR_LOW: begin
          frame_err_present_out <= 1'b1;
          frame_err_bit_out <= ~err_total;
          frame_warn_present_out <= 1'b0;
          frame_warn_bit_out <= 1'b0;
        end
        PROTO_SSI_ERR_HIGH: begin
          frame_err_present_out <= 1'b1;
          frame_err_bit_out <= err_total;
          frame_warn_present_out <= 1'b0;
          frame_warn_bit_out <= 1'b0;
        end
        PROTO_SPI_TRI, PROTO_SPI, PROTO_QUAD, PROTO_SSI: begin
          frame_err_present_out <= 1'b0;
          frame_err_bit_out <= 1'b0;
          frame_warn_present_out <= 1'b0;
          frame_warn_bit_out <= 1'b0;
        end
      endcase
    end
  end

endmodule // esc_unit

// >>> verif/esc_engine_model.sv
// Action engine model: answers each start with a done pulse
`timescale 1ns/100ps
module esc_engine_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Handshake
  input wire logic [15:0] start_in,
  input wire logic mismatch_in,
  output logic done_out,
  output logic mismatch_out
);
  logic [3:0] cnt; // Cycles left until done
  // Long enough that a second command lands while busy
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt <= 4'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt == 4'h1);
      if (|start_in) begin
        cnt <= 4'h8;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  // Result only valid with done, inverted otherwise
  assign mismatch_out = done_out ? mismatch_in : ~mismatch_in;
endmodule // esc_engine_model

// >>> verif/esc_unit_properties.sv
// Checker for the error signalling and command unit ports
`timescale 1ns/100ps
module esc_unit_properties (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] act_start_out,
  input wire logic twi_store_req_out,
  input wire logic substitute_target_out,
  input wire logic act_done_in,
  input wire logic frame_err_present_out,
  input wire logic frame_err_bit_out,
  input wire logic frame_warn_present_out,
  input wire logic frame_warn_bit_out,
  input wire logic port_b_line3_out,
  input wire logic command_busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_pin_never_high: assert property (port_b_line3_out == 1'b0)
    else $error("error pin level driven high");
  a_start_one_hot: assert property ($onehot0(act_start_out))
    else $error("more than one start line");
  a_start_not_busy: assert property (|act_start_out |-> !$past(command_busy_out))
    else $error("start while busy");
  a_busy_with_start: assert property (|act_start_out |-> command_busy_out ##1 command_busy_out)
    else $error("busy missing at start");
  a_busy_ends_done: assert property (command_busy_out && act_done_in |=> !command_busy_out)
    else $error("busy not cleared after done");
  a_store_goes_twi: assert property (|(act_start_out & 16'h0b07) |-> twi_store_req_out)
    else $error("store without two-wire request");
  a_twi_has_cause: assert property (twi_store_req_out |-> |(act_start_out & 16'h0b07))
    else $error("two-wire request without store");
  a_swap_substitutes: assert property (act_start_out[11] |=> substitute_target_out)
    else $error("target values not substituted");
  a_absent_err_zero: assert property (!frame_err_present_out |-> !frame_err_bit_out)
    else $error("error bit set while absent");
  a_absent_warn_zero: assert property (!frame_warn_present_out |-> !frame_warn_bit_out)
    else $error("warning bit set while absent");
endmodule // esc_unit_properties
bind esc_unit esc_unit_properties u_props (.sys_clk_in, .sys_rst_in, .act_start_out, .twi_store_req_out,
  .substitute_target_out, .act_done_in, .frame_err_present_out, .frame_err_bit_out, .frame_warn_present_out,
  .frame_warn_bit_out, .port_b_line3_out, .command_busy_out);

// >>> verif/esc_unit_bench.sv
// Self-checking bench for the error signalling and command unit
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module esc_unit_bench;
  import esc_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, mm = 0, done, mis, oe, pin, busy, wt;
  logic [9:0] adr = 0;
  logic [31:0] wd = 0, rdat;
  logic [9:0] cond = 0; // Condition inputs
  logic [15:0] act, last;
  logic ep, eb, wp, wb;
  logic [7:0] q;
  int err_count = 0, n_compared = 0, starts = 0, i;
  always #50 clk = ~clk;
  esc_unit #(.HOLD_STEP_CYCLES_P(4)) DUT (.sys_clk_in(clk), .sys_rst_in(rst), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h1),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .turns_link_error_in(cond[0]),
    .amplitude_clip_in(cond[2:1]), .amplitude_low_in(cond[4:3]), .eeprom_error_in(cond[5]),
    .checksum_error_in(cond[6]), .converter_overspeed_in(cond[7]), .quadrature_overspeed_in(cond[8]),
    .status_read_in(cond[9]), .act_start_out(act), .twi_store_req_out(), .substitute_target_out(),
    .act_done_in(done), .act_mismatch_in(mis), .frame_err_present_out(ep), .frame_err_bit_out(eb),
    .frame_warn_present_out(wp), .frame_warn_bit_out(wb), .port_b_line3_out(), .port_b_line3_oe_out(oe),
    .turns_clock_pin_out(pin), .command_busy_out(busy));
  esc_engine_model u_eng (.sys_clk_in(clk), .sys_rst_in(rst), .start_in(act), .mismatch_in(mm),
    .done_out(done), .mismatch_out(mis));
  // Count engine starts and keep the last one
  always @(posedge clk) if (|act) begin
    starts++;
    last = act;
  end
  // Bus access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    adr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wbusy;
    for (i = 0; i < 60 && busy !== 1'b0; i++) cyc(1);
    `CHK(busy, 1'b0)
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    acc(0, IDX_PROTOCOL, 0); `CHK(q, RST_PROTOCOL)
    acc(0, IDX_MASK, 0); `CHK(q, RST_MASK)
    acc(0, IDX_COMMAND, 0); `CHK(q, 8'h00)
    acc(0, 8'h20, 0); `CHK(q, 8'h00)
    $display("test reset done");
    cond <= 10'h0a0;
    for (int p = 0; p < 8; p++) begin
      acc(1, IDX_PROTOCOL, 8'(p));
      cyc(3);
      `CHK({ep, eb, wp, wb}, {(p inside {2, 5, 6, 7}), p == 6, p == 2 || p == 7, 1'b0})
    end
    acc(1, IDX_MASK, 8'h12);
    acc(0, IDX_MASK, 0); `CHK(q, 8'h12)
    cyc(3); `CHK({eb, wb}, 2'b11)
    // Only the checksum and eeprom terms pass; checksum must pull the low-active error bit
    acc(1, IDX_MASK, 8'he7);
    cond <= 10'h040;
    cyc(3); `CHK({eb, wb}, 2'b01)
    $display("test frame bits done");
    acc(1, IDX_PORT_CFG, 8'h01);
    cond <= 10'h000;
    acc(1, IDX_HOLD, 8'h03);
    cond <= 10'h020;
    @(posedge clk) cond <= 10'h000;
    cyc(2); `CHK(oe, 1'b1)
    for (i = 1; i < 40 && oe === 1'b1; i++) cyc(1);
    `CHK(i, 3 * 4)
    // Accumulated error stays after its cause until a status read clears it
    acc(1, IDX_HOLD, 8'h80);
    cond <= 10'h040;
    @(posedge clk) cond <= 10'h000;
    acc(0, IDX_UNIT_STATUS, 0); `CHK(q[1], 1'b1)
    cond <= 10'h200;
    @(posedge clk) cond <= 10'h000;
    acc(0, IDX_UNIT_STATUS, 0); `CHK(q[1], 1'b0)
    $display("test error pin done");
    for (int c = 1; c < 15; c++) if (c != 11) begin
      acc(1, IDX_COMMAND, 8'(c));
      cyc(1); `CHK(busy, 1'b1)
      acc(1, IDX_COMMAND, 8'h01);
      wbusy; `CHK(last, 16'h1 << (c - 1))
    end
    `CHK(starts, 13)
    mm <= 1'b1;
    acc(1, IDX_COMMAND, CMD_VERNIER_VERIFY);
    cyc(2); wbusy;
    acc(0, IDX_UNIT_STATUS, 0); `CHK(q[2], 1'b1)
    acc(1, IDX_COMMAND, CMD_EVENT_COUNT);
    acc(1, IDX_COMMAND, CMD_EVENT_COUNT);
    acc(1, IDX_COMMAND, 8'h00);
    acc(1, IDX_COMMAND, 8'h11);
    acc(1, IDX_COMMAND, 8'hff);
    acc(0, IDX_EVENT_COUNT, 0); `CHK(q, 8'h02)
    `CHK(starts, 14)
    acc(1, IDX_COMMAND, CMD_TURNS_CLK_HIGH); cyc(1); `CHK(pin, 1'b1)
    acc(1, IDX_PORT_CFG, 8'h02);
    acc(1, IDX_COMMAND, CMD_TURNS_CLK_LOW); cyc(1); `CHK(pin, 1'b1)
    acc(1, IDX_PORT_CFG, 8'h00);
    acc(1, IDX_COMMAND, CMD_TURNS_CLK_LOW); cyc(1); `CHK(pin, 1'b0)
    $display("test commands done");
    wrap_up;
  end
endmodule // esc_unit_bench
